// file: core/gyro_register_bank.v
// Register bank of a three-axis rate sensor behind a serial peripheral slave port
//
// Contract
// - Non-special registers read zero after reset
// - Primary power control resets to 0x40, sleeping
// - Self-test references reset to factory codes
// - Device sleeps from power-up until host changes
// - High/low pairs expose one 16-bit quantity
// - Rate sample bits 15:8 high, 7:0 low
// - Per-axis 16-bit trim, host read/write
// - Trim added to raw sample before output
// - Self-test reference holds 8-bit factory code
`timescale 1ns/100ps
`include "gyro_register_bank_map.vh"
module gyro_register_bank #(
   // Factory codes stand in for one-time-programmed values
   parameter [7:0] X_SELFTEST_CODE = 8'h80,
   parameter [7:0] Y_SELFTEST_CODE = 8'h80,
   parameter [7:0] Z_SELFTEST_CODE = 8'h80,
   // Arbitrary identity value
   parameter [7:0] IDENTITY_CODE   = 8'h5a
) (
   // Clock and reset
   input  wire        CLK_I,
   input  wire        RST_I,
   // Serial port pins
   input  wire        SPC_I,
   input  wire        CS_N_I,
   input  wire        SDI_I,
   output wire        SDO_O,
   output wire        SDO_OE_O,
   // Raw rate samples from the converter, same clock
   input  wire [15:0] RAW_X_I,
   input  wire [15:0] RAW_Y_I,
   input  wire [15:0] RAW_Z_I,
   input  wire        RAW_VALID_I,
   // Power state
   output wire        SLEEP_O
);

   // Synchronisers: first stage feeds only the second
   reg  [1:0]  spc_sync;
   reg  [1:0]  cs_sync;
   reg  [1:0]  sdi_sync;
   reg         spc_last;

   // Serial engine
   reg  [2:0]  bit_cnt;
   reg  [7:0]  rx_shift;
   reg  [7:0]  tx_shift;
   reg  [6:0]  addr;
   reg         header_done;
   reg         read_mode;

   // Register storage
   reg  [7:0]  x_rate_factory_selftest;
   reg  [7:0]  y_rate_factory_selftest;
   reg  [7:0]  z_rate_factory_selftest;
   reg  [15:0] x_rate_bias_trim;
   reg  [15:0] y_rate_bias_trim;
   reg  [15:0] z_rate_bias_trim;
   reg  [7:0]  signal_path_clear;
   reg  [7:0]  user_control_bits;
   reg  [7:0]  power_control_primary;
   reg  [7:0]  power_control_secondary;
   reg  [7:0]  queue_data_port;
   reg         soft_reset;
   reg         sig_cond_clear;

   wire        cs_active;
   wire        spc_rise;
   wire        spc_fall;
   wire [7:0]  next_rx;
   wire        byte_done;
   wire        wr_en;
   wire        sleep;
   wire [47:0] raw_all;
   wire [47:0] trim_all;
   wire [47:0] sample_all;
   wire [2:0]  axis_load;
   wire [15:0] x_rate_sample;
   wire [15:0] y_rate_sample;
   wire [15:0] z_rate_sample;
   reg  [7:0]  rd_data;

   // Only the power registers accept writes while asleep
   function writable;
      input [6:0] a;
      input       asleep;
      begin
         case (a)
            `OFS_X_SELFTEST, `OFS_Y_SELFTEST, `OFS_Z_SELFTEST,
            `OFS_X_TRIM_HIGH, `OFS_X_TRIM_LOW, `OFS_Y_TRIM_HIGH,
            `OFS_Y_TRIM_LOW, `OFS_Z_TRIM_HIGH, `OFS_Z_TRIM_LOW,
            `OFS_SIGNAL_PATH, `OFS_USER_CONTROL, `OFS_QUEUE_DATA: begin
               writable = ~asleep;
            end
            `OFS_POWER_PRIMARY, `OFS_POWER_SECONDARY: begin
               writable = 1'b1;
            end
            default: begin
               writable = 1'b0;
            end
         endcase
      end
   endfunction

   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         spc_sync <= 2'h3;
         cs_sync  <= 2'h3;
         sdi_sync <= 2'h0;
         spc_last <= 1'b1;
      end else begin
         spc_sync <= {spc_sync[0], SPC_I};
         cs_sync  <= {cs_sync[0], CS_N_I};
         sdi_sync <= {sdi_sync[0], SDI_I};
         spc_last <= spc_sync[1];
      end
   end

   assign cs_active = ~cs_sync[1];
   assign spc_rise  = cs_active & spc_sync[1] & ~spc_last;
   assign spc_fall  = cs_active & ~spc_sync[1] & spc_last;
   assign next_rx   = {rx_shift[6:0], sdi_sync[1]};
   assign byte_done = spc_rise & (bit_cnt == `SPI_BITS_PER_BYTE);
   assign wr_en     = byte_done & header_done & ~read_mode;

   // Serial frame: header byte, then data bytes with address auto-increment
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         bit_cnt     <= 3'h0;
         rx_shift    <= 8'h00;
         tx_shift    <= 8'h00;
         addr        <= 7'h00;
         header_done <= 1'b0;
         read_mode   <= 1'b0;
      end else if (!cs_active) begin
         bit_cnt     <= 3'h0;
         header_done <= 1'b0;
      end else begin
         if (spc_rise) begin
            rx_shift <= next_rx;
            bit_cnt  <= bit_cnt + 3'h1;
            if (byte_done && !header_done) begin
               read_mode   <= next_rx[`BIT_SPI_READ];
               addr        <= next_rx[6:0];
               header_done <= 1'b1;
            end else if (wr_en) begin
               addr <= addr + 7'h01;
            end
         end
         if (spc_fall) begin
            if (bit_cnt == 3'h0 && header_done && read_mode) begin
               tx_shift <= rd_data;
               addr     <= addr + 7'h01;
            end else begin
               tx_shift <= {tx_shift[6:0], 1'b0};
            end
         end
      end
   end

   // Output changes on the falling clock, so the host samples a settled bit
   assign SDO_O    = tx_shift[7];
   assign SDO_OE_O = cs_active & header_done & read_mode;

   // Register writes
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         x_rate_factory_selftest <= X_SELFTEST_CODE;
         y_rate_factory_selftest <= Y_SELFTEST_CODE;
         z_rate_factory_selftest <= Z_SELFTEST_CODE;
         x_rate_bias_trim        <= 16'h0000;
         y_rate_bias_trim        <= 16'h0000;
         z_rate_bias_trim        <= 16'h0000;
         signal_path_clear       <= `RST_ZERO;
         user_control_bits       <= `RST_ZERO;
         power_control_primary   <= `RST_POWER_PRIMARY;
         power_control_secondary <= `RST_ZERO;
         queue_data_port         <= `RST_ZERO;
         soft_reset              <= 1'b0;
         sig_cond_clear          <= 1'b0;
      end else if (soft_reset) begin
         // Software reset returns every register to its power-up value
         x_rate_factory_selftest <= X_SELFTEST_CODE;
         y_rate_factory_selftest <= Y_SELFTEST_CODE;
         z_rate_factory_selftest <= Z_SELFTEST_CODE;
         x_rate_bias_trim        <= 16'h0000;
         y_rate_bias_trim        <= 16'h0000;
         z_rate_bias_trim        <= 16'h0000;
         signal_path_clear       <= `RST_ZERO;
         user_control_bits       <= `RST_ZERO;
         power_control_primary   <= `RST_POWER_PRIMARY;
         power_control_secondary <= `RST_ZERO;
         queue_data_port         <= `RST_ZERO;
         soft_reset              <= 1'b0;
         sig_cond_clear          <= 1'b0;
      end else begin
         soft_reset     <= 1'b0;
         sig_cond_clear <= 1'b0;
         if (wr_en && writable(addr, sleep)) begin
            case (addr)
               `OFS_X_SELFTEST:      x_rate_factory_selftest <= next_rx;
               `OFS_Y_SELFTEST:      y_rate_factory_selftest <= next_rx;
               `OFS_Z_SELFTEST:      z_rate_factory_selftest <= next_rx;
               `OFS_X_TRIM_HIGH:     x_rate_bias_trim[15:8]  <= next_rx;
               `OFS_X_TRIM_LOW:      x_rate_bias_trim[7:0]   <= next_rx;
               `OFS_Y_TRIM_HIGH:     y_rate_bias_trim[15:8]  <= next_rx;
               `OFS_Y_TRIM_LOW:      y_rate_bias_trim[7:0]   <= next_rx;
               `OFS_Z_TRIM_HIGH:     z_rate_bias_trim[15:8]  <= next_rx;
               `OFS_Z_TRIM_LOW:      z_rate_bias_trim[7:0]   <= next_rx;
               `OFS_SIGNAL_PATH:     signal_path_clear       <= next_rx;
               `OFS_USER_CONTROL: begin
                  // Conditioning clear is a pulse; the bit never reads back set
                  user_control_bits <= next_rx & 8'hfe;
                  sig_cond_clear    <= next_rx[`BIT_SIG_COND_CLEAR];
               end
               `OFS_POWER_PRIMARY: begin
                  // Reset request bit is a one-cycle strobe and always reads back zero
                  power_control_primary <= next_rx & 8'h7f;
                  soft_reset            <= next_rx[`BIT_DEVICE_RESET];
               end
               `OFS_POWER_SECONDARY: power_control_secondary <= next_rx;
               `OFS_QUEUE_DATA:      queue_data_port         <= next_rx;
               default: begin
               end
            endcase
         end
      end
   end

   assign sleep   = power_control_primary[`BIT_SLEEP];
   assign SLEEP_O = sleep;

   // Sample path per axis; standby bits of the secondary register run z, y, x from bit 0
   assign raw_all  = {RAW_Z_I, RAW_Y_I, RAW_X_I};
   assign trim_all = {z_rate_bias_trim, y_rate_bias_trim, x_rate_bias_trim};

   genvar axis;
   generate
      for (axis = 0; axis < 3; axis = axis + 1) begin : rate_axis
         // Samples freeze while asleep or in standby
         assign axis_load[axis] = RAW_VALID_I & ~sleep
                                  & ~power_control_primary[`BIT_RATE_STANDBY]
                                  & ~power_control_secondary[2 - axis];
         rate_axis_path u_path (
            .clk_i    (CLK_I),
            .rst_i    (RST_I),
            .clear_i  (soft_reset | sig_cond_clear),
            .load_i   (axis_load[axis]),
            .raw_i    (raw_all[axis*16 +: 16]),
            .trim_i   (trim_all[axis*16 +: 16]),
            .sample_o (sample_all[axis*16 +: 16])
         );
      end
   endgenerate

   assign x_rate_sample = sample_all[15:0];
   assign y_rate_sample = sample_all[31:16];
   assign z_rate_sample = sample_all[47:32];

   // Read multiplexer; the queue is not built, so its level reads zero
   always @* begin
      case (addr)
         `OFS_X_SELFTEST:      rd_data = x_rate_factory_selftest;
         `OFS_Y_SELFTEST:      rd_data = y_rate_factory_selftest;
         `OFS_Z_SELFTEST:      rd_data = z_rate_factory_selftest;
         `OFS_X_TRIM_HIGH:     rd_data = x_rate_bias_trim[15:8];
         `OFS_X_TRIM_LOW:      rd_data = x_rate_bias_trim[7:0];
         `OFS_Y_TRIM_HIGH:     rd_data = y_rate_bias_trim[15:8];
         `OFS_Y_TRIM_LOW:      rd_data = y_rate_bias_trim[7:0];
         `OFS_Z_TRIM_HIGH:     rd_data = z_rate_bias_trim[15:8];
         `OFS_Z_TRIM_LOW:      rd_data = z_rate_bias_trim[7:0];
         `OFS_X_SAMPLE_HIGH:   rd_data = x_rate_sample[15:8];
         `OFS_X_SAMPLE_LOW:    rd_data = x_rate_sample[7:0];
         `OFS_Y_SAMPLE_HIGH:   rd_data = y_rate_sample[15:8];
         `OFS_Y_SAMPLE_LOW:    rd_data = y_rate_sample[7:0];
         `OFS_Z_SAMPLE_HIGH:   rd_data = z_rate_sample[15:8];
         `OFS_Z_SAMPLE_LOW:    rd_data = z_rate_sample[7:0];
         `OFS_SIGNAL_PATH:     rd_data = signal_path_clear;
         `OFS_USER_CONTROL:    rd_data = user_control_bits;
         `OFS_POWER_PRIMARY:   rd_data = power_control_primary;
         `OFS_POWER_SECONDARY: rd_data = power_control_secondary;
         `OFS_QUEUE_LEVEL_HI:  rd_data = `RST_ZERO;
         `OFS_QUEUE_LEVEL_LO:  rd_data = `RST_ZERO;
         `OFS_QUEUE_DATA:      rd_data = queue_data_port;
         `OFS_IDENTITY:        rd_data = IDENTITY_CODE;
         default:              rd_data = `RST_ZERO;
      endcase
   end

endmodule

// file: core/gyro_register_bank_map.vh
// Register offsets, field positions, reset values and serial frame constant for the rate sensor bank
`ifndef GYRO_REGISTER_BANK_MAP_VH
`define GYRO_REGISTER_BANK_MAP_VH

// Register offsets (7-bit serial address)
`define OFS_X_SELFTEST      7'h00
`define OFS_Y_SELFTEST      7'h01
`define OFS_Z_SELFTEST      7'h02
`define OFS_X_TRIM_HIGH     7'h13
`define OFS_X_TRIM_LOW      7'h14
`define OFS_Y_TRIM_HIGH     7'h15
`define OFS_Y_TRIM_LOW      7'h16
`define OFS_Z_TRIM_HIGH     7'h17
`define OFS_Z_TRIM_LOW      7'h18
`define OFS_X_SAMPLE_HIGH   7'h43
`define OFS_X_SAMPLE_LOW    7'h44
`define OFS_Y_SAMPLE_HIGH   7'h45
`define OFS_Y_SAMPLE_LOW    7'h46
`define OFS_Z_SAMPLE_HIGH   7'h47
`define OFS_Z_SAMPLE_LOW    7'h48
`define OFS_SIGNAL_PATH     7'h68
`define OFS_USER_CONTROL    7'h6a
`define OFS_POWER_PRIMARY   7'h6b
`define OFS_POWER_SECONDARY 7'h6c
`define OFS_QUEUE_LEVEL_HI  7'h72
`define OFS_QUEUE_LEVEL_LO  7'h73
`define OFS_QUEUE_DATA      7'h74
`define OFS_IDENTITY        7'h75

// Reset values
`define RST_ZERO            8'h00
`define RST_POWER_PRIMARY   8'h40

// Field positions
`define BIT_DEVICE_RESET    7
`define BIT_SLEEP           6
`define BIT_RATE_STANDBY    4
`define BIT_SIG_COND_CLEAR  0
`define BIT_SPI_READ        7

// Serial frame
`define SPI_BITS_PER_BYTE   3'h7

`endif

// file: core/rate_axis_path.v
// One axis of the rate path: bias trim added to the raw sample, held for readout
`timescale 1ns/100ps
module rate_axis_path (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Control
   input  wire        clear_i,
   input  wire        load_i,
   // Data
   input  wire [15:0] raw_i,
   input  wire [15:0] trim_i,
   output reg  [15:0] sample_o
);

   wire [15:0] next_sample;

   // Two's complement sum wraps in 16 bits, as the output register is 16 bits wide
   assign next_sample = raw_i + trim_i;

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sample_o <= 16'h0000;
      end else if (clear_i) begin
         sample_o <= 16'h0000;
      end else if (load_i) begin
         sample_o <= next_sample;
      end
   end

endmodule

// file: tb/gyro_register_bank_assertions.sv
// Concurrent checks on the serial pins and power flag of the rate sensor bank
`timescale 1ns/100ps
module gyro_register_bank_checker (
   // Clock and reset
   input wire CLK_I,
   input wire RST_I,
   // Serial pins
   input wire CS_N_I,
   input wire SPC_I,
   input wire SDO_O,
   input wire SDO_OE_O,
   // Power state
   input wire SLEEP_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);

   a_sleep_after_reset: assert property ($fell(RST_I) |-> SLEEP_O)
      else $error("sleep flag low after reset release");
   a_bus_quiet_reset: assert property ($fell(RST_I) |-> !SDO_OE_O && !SDO_O)
      else $error("serial output active after reset release");
   a_oe_idle_cs: assert property (CS_N_I [*5] |-> !SDO_OE_O)
      else $error("serial output enabled without chip select");
   a_oe_rise_cs: assert property ($rose(SDO_OE_O) |-> !CS_N_I)
      else $error("serial output enabled outside a frame");
   a_oe_fall_cs: assert property ($fell(SDO_OE_O) |-> CS_N_I)
      else $error("serial output released in mid frame");
   // The address byte alone takes far longer than eight cycles
   a_header_quiet: assert property ($fell(CS_N_I) |=> !SDO_OE_O [*8])
      else $error("serial output enabled during address byte");
   a_sdo_hold_high: assert property ((SPC_I && !CS_N_I) [*5] |-> $stable(SDO_O))
      else $error("serial data changed while serial clock high");
   a_sleep_hold_idle: assert property (CS_N_I [*8] |-> $stable(SLEEP_O))
      else $error("sleep flag changed with no host frame");
endmodule

// file: tb/gyro_register_bank_bench.sv
// Self-checking bench: serial register traffic against the rate sensor bank
`timescale 1ns/100ps
module gyro_register_bank_bench;
   localparam logic [7:0] XC = 8'h3c;
   localparam logic [7:0] YC = 8'h5d;
   localparam logic [7:0] ZC = 8'h7e;
   localparam logic [7:0] IDC = 8'ha7; // Arbitrary identity value
   logic        clk = 1'h0;
   logic        rst = 1'h1;
   logic        raw_valid = 1'h0;
   logic [15:0] raw_x = 16'h0000;
   logic [15:0] raw_y = 16'h0000;
   logic [15:0] raw_z = 16'h0000;
   logic [15:0] trim [3] = '{16'h8001, 16'hffff, 16'h7fff};
   logic [15:0] raw [3] = '{16'h8000, 16'h0005, 16'h0001};
   logic [6:0]  ra [23] = '{7'h00, 7'h01, 7'h02, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18,
      7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h48, 7'h68, 7'h6a, 7'h6b, 7'h6c, 7'h72, 7'h73,
      7'h74, 7'h75};
   wire         spc;
   wire         cs_n;
   wire         sdi;
   wire         sdo;
   wire         sleep;
   wire         sdo_oe;
   wire         sdo_line;
   int          errors = 0;
   int          compares = 0;

   always #25 clk = ~clk;

   // A released data line shows the inverse, so a late enable corrupts the read
   assign sdo_line = sdo_oe ? sdo : ~sdo;

   spi_host_model i_spi_host_model (.clk_i(clk), .spc_o(spc), .cs_n_o(cs_n), .sdi_o(sdi),
      .sdo_i(sdo_line));

   gyro_register_bank #(.X_SELFTEST_CODE(XC), .Y_SELFTEST_CODE(YC), .Z_SELFTEST_CODE(ZC),
      .IDENTITY_CODE(IDC)) i_gyro_register_bank (.CLK_I(clk), .RST_I(rst), .SPC_I(spc),
      .CS_N_I(cs_n), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .RAW_X_I(raw_x),
      .RAW_Y_I(raw_y), .RAW_Z_I(raw_z), .RAW_VALID_I(raw_valid), .SLEEP_O(sleep));

   function automatic logic [7:0] rst_val(input logic [6:0] a);
      case (a)
         7'h00: return XC;
         7'h01: return YC;
         7'h02: return ZC;
         7'h6b: return 8'h40;
         7'h75: return IDC;
         default: return 8'h00;
      endcase
   endfunction

   function automatic logic [15:0] pair(input int k);
      return {i_spi_host_model.bytes[2*k], i_spi_host_model.bytes[2*k+1]};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wr1(input logic [6:0] a, input logic [7:0] d);
      i_spi_host_model.bytes[0] = d;
      i_spi_host_model.xfer(1'h0, a, 1);
   endtask

   task automatic rd1(input logic [6:0] a, input logic [7:0] exp);
      i_spi_host_model.xfer(1'h1, a, 1);
      check(i_spi_host_model.bytes[0], exp);
   endtask

   task automatic pulse();
      raw_x = raw[0];
      raw_y = raw[1];
      raw_z = raw[2];
      raw_valid = 1'h1;
      @(posedge clk);
      #1;
      raw_valid = 1'h0;
      @(posedge clk);
      #1;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      summarize();
   end

   initial begin
      repeat (20) @(posedge clk);
      #1;
      rst = 1'h0;
      repeat (3) @(posedge clk);
      #1;
      check(sleep, 16'h0001);
      for (int k = 0; k < 23; k++)
         rd1(ra[k], rst_val(ra[k]));
      // Asleep: trim write dropped and samples frozen
      wr1(7'h13, 8'h55);
      pulse();
      rd1(7'h13, 8'h00);
      rd1(7'h43, 8'h00);
      wr1(7'h6b, 8'h00);
      check(sleep, 16'h0000);
      // Slow clock on bursts so the hold-high check sees long high phases
      i_spi_host_model.hp = 6;
      for (int k = 0; k < 3; k++) begin
         i_spi_host_model.bytes[2*k] = trim[k][15:8];
         i_spi_host_model.bytes[2*k+1] = trim[k][7:0];
      end
      i_spi_host_model.xfer(1'h0, 7'h13, 6);
      i_spi_host_model.xfer(1'h1, 7'h13, 6);
      for (int k = 0; k < 3; k++)
         check(pair(k), trim[k]);
      pulse();
      i_spi_host_model.xfer(1'h1, 7'h43, 6);
      for (int k = 0; k < 3; k++)
         check(pair(k), trim[k] + raw[k]);
      i_spi_host_model.hp = 4;
      wr1(7'h43, 8'hff);
      wr1(7'h75, 8'h00);
      wr1(7'h72, 8'h11);
      rd1(7'h43, 8'h00);
      rd1(7'h75, IDC);
      rd1(7'h72, 8'h00);
      // Conditioning clear empties the samples; x standby then freezes x only
      wr1(7'h6a, 8'h01);
      rd1(7'h6a, 8'h00);
      rd1(7'h46, 8'h00);
      wr1(7'h6c, 8'h04);
      pulse();
      rd1(7'h44, 8'h00);
      rd1(7'h46, 8'h04);
      // Software reset brings back the power-up state
      wr1(7'h6b, 8'h80);
      rd1(7'h6b, 8'h40);
      check(sleep, 16'h0001);
      rd1(7'h13, 8'h00);
      rd1(7'h00, XC);
      rd1(7'h6c, 8'h00);
      check(i_spi_host_model.selftest_lsb(8'h01, 2), 16'h028f);
      summarize();
   end
endmodule

bind gyro_register_bank gyro_register_bank_checker i_gyro_register_bank_checker (.CLK_I(CLK_I),
   .RST_I(RST_I), .CS_N_I(CS_N_I), .SPC_I(SPC_I), .SDO_O(SDO_O), .SDO_OE_O(SDO_OE_O),
   .SLEEP_O(SLEEP_O));

// file: tb/spi_host_model.sv
// Host side of the serial link: mode 3 frames, address byte then data bytes
`timescale 1ns/100ps
module spi_host_model (
   // Clock
   input  wire        clk_i,
   // Serial pins
   output logic       spc_o,
   output logic       cs_n_o,
   output logic       sdi_o,
   input  wire        sdo_i
);
   logic [7:0] bytes [0:7];
   int         hp = 4;

   initial begin
      spc_o = 1'h1;
      cs_n_o = 1'h1;
      sdi_o = 1'h0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // Host-side conversion of a stored self-test code into LSB at a full-scale setting
   function automatic logic [15:0] selftest_lsb(input logic [7:0] code, input int fs);
      int v;
      v = $rtoi(2620.0 / (2.0 ** fs) * (1.01 ** ($itor(code) - 1.0)));
      return v[15:0];
   endfunction

   // Half periods shorter than three system cycles would outrun the synchronisers
   task automatic xfer(input logic rd, input logic [6:0] a, input int n);
      logic [7:0] sh;
      cs_n_o = 1'h0;
      step(hp);
      for (int k = 0; k <= n; k++) begin
         sh = (k == 0) ? {rd, a} : (rd ? 8'h00 : bytes[k-1]);
         for (int b = 7; b >= 0; b--) begin
            spc_o = 1'h0;
            sdi_o = sh[b];
            step(hp);
            spc_o = 1'h1;
            if (k > 0)
               sh[b] = sdo_i;
            step(hp);
         end
         if (k > 0 && rd)
            bytes[k-1] = sh;
      end
      cs_n_o = 1'h1;
      sdi_o = ~sdi_o;
      step(2 * hp);
   endtask
endmodule
